// [bench/adc_irq_dma_trigger_control_test.sv]
/*
  Self-checking bench for the acquisition control register.
  Assumes the control block with its default bus parameter.
*/
module adc_irq_dma_trigger_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_I = '0;
  logic RST_I = '1;
  logic [3:0] IO_ADDR_I = '0;
  logic [7:0] IO_DATA_I = '0;
  logic IO_WR_I = '0, IO_RD_I = '0, ENHANCED_SET_SELECT_I = '0;
  logic COMPAT_MODE_JUMPER_I = '0, FIFO_SUPERSET_JUMPER_I = '0;
  logic ADC_DONE_I = '0, FIFO_IRQ_EVENT_I = '0, IRQ_CLEAR_I = '0;
  logic DMA_REQ_I = '0, CONV_DISABLE_CLR_I = '0, SOFT_STROBE_I = '0;
  logic DIGITAL_INPUT_ZERO_I = '0, PACER_COUNTER_OUTPUT_I = '0;
  logic armed = '0;
  logic TC_I, IO_DATA_OE_O, DRQ_O, DRQ_OE_O, ADC_TRIGGER_O;
  logic CONV_DISABLE_O, FIFO_ROUTE_O;
  logic [7:0] IO_DATA_O;
  logic [15:0] IRQ_O, IRQ_OE_O;
  int fail_count = 0, n_checks = 0, cycles = 0;

  aidt_ctrl dut (.*);
  aidt_host_dma #(.N_XFER(4)) host (.clk_i(CLK_I), .rst_i(RST_I),
    .armed_i(armed), .drq_i(DRQ_O), .drq_oe_i(DRQ_OE_O), .tc_o(TC_I));

  always #10 CLK_I = ~CLK_I;
  // the whole run needs well under a thousand cycles
  always @(posedge CLK_I) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      complete_run();
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task step(int n);
    repeat (n) @(posedge CLK_I);
    #2;
  endtask
  task bad(string m);
    fail_count++;
    $display("BAD %0t %s", $time, m);
  endtask
  task chk_bit(logic got, logic exp, string m);
    n_checks++;
    if (got !== exp) bad(m);
  endtask
  task chk_byte(logic [7:0] got, logic [7:0] exp, string m);
    n_checks++;
    if (got !== exp) bad(m);
  endtask
  task chk_lines(logic [15:0] got, logic [15:0] exp, string m);
    n_checks++;
    if (got !== exp) bad(m);
  endtask
  task wr(logic [7:0] d);
    IO_ADDR_I = 4'h9;
    IO_DATA_I = d;
    IO_WR_I = '1;
    step(1);
    IO_WR_I = '0;
    step(1);
  endtask
  task rd(logic [3:0] a, logic [7:0] exp, logic oe);
    IO_ADDR_I = a;
    IO_RD_I = '1;
    step(1);
    IO_RD_I = '0;
    chk_bit(IO_DATA_OE_O, oe, "read answer");
    if (oe) chk_byte(IO_DATA_O, exp, "read data");
    // let an edge pass so a following read does not re-raise the strobe
    step(1);
  endtask
  // event pulse, then pending line, then clear
  task irq_pulse(bit fifo, logic [15:0] exp);
    if (fifo) FIFO_IRQ_EVENT_I = '1;
    else ADC_DONE_I = '1;
    step(1);
    FIFO_IRQ_EVENT_I = '0;
    ADC_DONE_I = '0;
    step(1);
    chk_lines(IRQ_O, exp, "pending line");
    IRQ_CLEAR_I = '1;
    step(1);
    IRQ_CLEAR_I = '0;
    step(2);
    chk_lines(IRQ_O, 16'h0000, "line after clear");
  endtask
  // 0 software strobe, 1 toggle digital input, 2 toggle pacer
  task ev(int src, logic exp);
    if (src == 0) SOFT_STROBE_I = '1;
    if (src == 1) DIGITAL_INPUT_ZERO_I = ~DIGITAL_INPUT_ZERO_I;
    if (src == 2) PACER_COUNTER_OUTPUT_I = ~PACER_COUNTER_OUTPUT_I;
    step(1);
    SOFT_STROBE_I = '0;
    chk_bit(ADC_TRIGGER_O, exp, "trigger");
    step(1);
    chk_bit(ADC_TRIGGER_O, '0, "trigger width");
  endtask
  function logic [15:0] line_mask(logic enh, logic [3:0] c);
    if (!enh && c < 4'h2) return 16'h0000;
    if (enh && (c inside {4'h0, 4'h1, 4'h8, 4'hD})) return 16'h0000;
    if (c == 4'h2 || c == 4'h9) return 16'h0200;
    return 16'h0001 << c;
  endfunction

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    step(5);
    RST_I = '0;
    rd(4'h9, 8'h00, '1);
    rd(4'h8, 8'h00, '0);
    chk_lines(IRQ_OE_O, 16'h0000, "idle enables");
    ENHANCED_SET_SELECT_I = '1;
    for (int c = 0; c < 16; c++) begin
      wr({c[3:0], 4'h0});
      chk_lines(IRQ_OE_O, line_mask('1, c[3:0]), "enh");
      irq_pulse('0, line_mask('1, c[3:0]));
    end
    ENHANCED_SET_SELECT_I = '0;
    for (int c = 0; c < 8; c++) begin
      wr({1'b1, c[2:0], 4'h0});
      chk_lines(IRQ_OE_O, line_mask('0, {1'b0, c[2:0]}), "leg");
      irq_pulse('0, line_mask('0, {1'b0, c[2:0]}));
    end
    wr(8'h38);
    rd(4'h9, 8'h38, '1);
    irq_pulse('0, 16'h0000);
    irq_pulse('1, 16'h0000);
    FIFO_SUPERSET_JUMPER_I = '1;
    irq_pulse('1, 16'h0008);
    wr(8'h31);
    ev(0, '1);
    wr(8'h30);
    ev(0, '1);
    wr(8'h32);
    ev(0, '0);
    ev(1, '1);
    ev(1, '1);
    wr(8'h33);
    ev(2, '1);
    ev(2, '0);
    ev(1, '0);
    wr(8'h30);
    DMA_REQ_I = '1;
    step(2);
    chk_bit(DRQ_OE_O, '0, "request released");
    chk_bit(FIFO_ROUTE_O, '0, "direct route");
    COMPAT_MODE_JUMPER_I = '1;
    armed = '1;
    wr(8'h34);
    chk_bit(DRQ_OE_O, '1, "request driven");
    chk_bit(DRQ_O, '1, "request level");
    chk_bit(FIFO_ROUTE_O, '1, "buffered route");
    for (int i = 0; i < 20 && CONV_DISABLE_O !== 1'b1; i++) step(1);
    chk_bit(CONV_DISABLE_O, '1, "count stop");
    step(1);
    chk_lines(IRQ_O, 16'h0008, "count interrupt");
    ev(0, '0);
    CONV_DISABLE_CLR_I = '1;
    step(1);
    CONV_DISABLE_CLR_I = '0;
    chk_bit(CONV_DISABLE_O, '0, "resume");
    ev(0, '1);
    armed = '0;
    DMA_REQ_I = '0;
    wr(8'h30);
    chk_bit(DRQ_OE_O, '0, "request released again");
    complete_run();
  end
endmodule

// [bench/aidt_host_dma.sv]
/*
  Host-side DMA controller model: counts granted requests and returns
  one terminal-count pulse after a programmed number of transfers.
  Assumes a synchronous clock shared with the control block.
*/
module aidt_host_dma #(
  parameter int N_XFER = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic armed_i,
  input wire logic drq_i,
  input wire logic drq_oe_i,
  output logic tc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  logic line;
  // an undriven request wire is pulled low, not left at its last value
  assign line = drq_oe_i ? drq_i : 1'b0;
  // ---------------------------------------------------------------
  // transfer counter
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i || !armed_i) begin
      cnt = 0;
      tc_o <= #2 1'b0;
    end else if (line && cnt < N_XFER) begin
      cnt = cnt + 1;
      tc_o <= #2 (cnt == N_XFER);
    end else begin
      tc_o <= #2 1'b0;
    end
  end
endmodule

// [src/aidt_ctrl.sv]
/*
  Interrupt line select, DMA enable and trigger select register of an
  analog acquisition board, at I/O offset 0x9 of the host byte bus.
  Assumes host strobes and all event inputs are synchronous to CLK_I,
  and that the board drives the shared interrupt and DMA request wires
  through external tri-state buffers fed by the *_OE_O outputs.
*/
// Operation
// - enhanced-set bit picks nibble or adc enable layout
// - enhanced codes map to IRQ9/2,3-7,10-12,14,15
// - invalid enhanced codes drive no line; reset 0000
// - legacy 000/001 off, 010 gives IRQ9/2, 011..111 give IRQ3..IRQ7
// - legacy bit 7 gates ADC interrupts
// - FIFO interrupt enable needs superset jumper
// - DMA requests tri-stated while DMA disabled
// - trigger source: software, digital input edges, pacer rise
// - DMA enabled routes results through FIFO
// - terminal count in DMA mode raises interrupt
// - compat jumper: terminal count disables conversions
// - writing zero to disable register resumes triggers
// - don't-care bits have no effect
`include "aidt_defines.svh"

module aidt_ctrl #(
  parameter bit AT_BUS = 1'b1
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [3:0] IO_ADDR_I,
  input wire logic IO_WR_I,
  input wire logic IO_RD_I,
  input wire logic [7:0] IO_DATA_I,
  output logic [7:0] IO_DATA_O,
  output logic IO_DATA_OE_O,
  input wire logic ENHANCED_SET_SELECT_I,
  input wire logic COMPAT_MODE_JUMPER_I,
  input wire logic FIFO_SUPERSET_JUMPER_I,
  input wire logic ADC_DONE_I,
  input wire logic FIFO_IRQ_EVENT_I,
  input wire logic IRQ_CLEAR_I,
  input wire logic DMA_REQ_I,
  input wire logic TC_I,
  input wire logic CONV_DISABLE_CLR_I,
  input wire logic SOFT_STROBE_I,
  input wire logic DIGITAL_INPUT_ZERO_I,
  input wire logic PACER_COUNTER_OUTPUT_I,
  output logic [15:0] IRQ_O,
  output logic [15:0] IRQ_OE_O,
  output logic DRQ_O,
  output logic DRQ_OE_O,
  output logic ADC_TRIGGER_O,
  output logic CONV_DISABLE_O,
  output logic FIFO_ROUTE_O
);

  if (AT_BUS !== 1'b0 && AT_BUS !== 1'b1) begin : g_bad_bus
    $error("aidt_ctrl: AT_BUS must be 0 or 1");
  end

  // ---------------------------------------------------------------
  // register access
  // ---------------------------------------------------------------
  aidt_pkg::aidt_ctrl_s ctrl;
  logic pending;
  logic conv_dis;

  wire hit = (IO_ADDR_I == `AIDT_CTRL_OFS);
  wire wr_hit = IO_WR_I & hit;
  wire rd_hit = IO_RD_I & hit;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ctrl <= `AIDT_CTRL_RST;
    end else if (wr_hit) begin
      // the byte is stored whole; how bits 7:4 decode depends on layout
      ctrl <= IO_DATA_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      IO_DATA_O <= 8'h00;
      IO_DATA_OE_O <= 1'b0;
    end else begin
      IO_DATA_O <= rd_hit ? ctrl : 8'h00;
      IO_DATA_OE_O <= rd_hit;
    end
  end

  // ---------------------------------------------------------------
  // interrupt line decode
  // ---------------------------------------------------------------
  wire enh = ENHANCED_SET_SELECT_I;
  wire adc_irq_enable = ctrl.line_nib[3];
  wire [2:0] legacy_irq_line_code = ctrl.line_nib[2:0];
  wire [3:0] enhanced_irq_line_code = ctrl.line_nib;
  // legacy codes 010..111 coincide with enhanced 0010..0111
  wire [3:0] code = enh ? enhanced_irq_line_code
                        : {1'b0, legacy_irq_line_code};
  wire [3:0] low_high = AT_BUS ? `AIDT_LINE_AT : `AIDT_LINE_XT;

  function automatic aidt_pkg::aidt_line_s decode(input logic [3:0] c,
                                                   input logic [3:0] lh);
    aidt_pkg::aidt_line_s r;
    r.valid = 1'b1;
    r.line = c;
    case (c)
      4'h0, 4'h1, 4'h8, 4'hD: r.valid = 1'b0;
      `AIDT_CODE_IRQ92_A, `AIDT_CODE_IRQ92_B: r.line = lh;
      default: r.line = c;
    endcase
    return r;
  endfunction

  aidt_pkg::aidt_line_s sel;
  assign sel = decode(code, low_high);
  wire [15:0] line_onehot = sel.valid ? (16'h0001 << sel.line)
                                      : 16'h0000;

  // ---------------------------------------------------------------
  // interrupt sources
  // ---------------------------------------------------------------
  wire dma_en = ctrl.dma_request_enable;
  // the enhanced layout has no ADC enable bit; ADC interrupts are always enabled there
  wire adc_ok = enh | adc_irq_enable;
  // without the superset jumper the enable bit is ignored
  wire fifo_ok = ctrl.fifo_irq_enable & FIFO_SUPERSET_JUMPER_I;
  wire adc_set = ADC_DONE_I & adc_ok;
  wire fifo_set = FIFO_IRQ_EVENT_I & fifo_ok;
  wire tc_set = TC_I & dma_en & sel.valid;
  wire any_set = adc_set | fifo_set | tc_set;

  // set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pending <= 1'b0;
    end else if (any_set) begin
      pending <= 1'b1;
    end else if (IRQ_CLEAR_I) begin
      pending <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      IRQ_O <= 16'h0000;
      IRQ_OE_O <= 16'h0000;
    end else begin
      IRQ_O <= pending ? line_onehot : 16'h0000;
      IRQ_OE_O <= line_onehot;
    end
  end

  // ---------------------------------------------------------------
  // DMA and conversion disable
  // ---------------------------------------------------------------
  wire tc_stop = TC_I & dma_en & COMPAT_MODE_JUMPER_I;

  // a stop arriving with the resume write still stops conversions
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      conv_dis <= 1'b0;
    end else if (tc_stop) begin
      conv_dis <= 1'b1;
    end else if (CONV_DISABLE_CLR_I) begin
      conv_dis <= 1'b0;
    end
  end
  assign CONV_DISABLE_O = conv_dis;

  // the host is trusted to program its controller before enabling
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      DRQ_O <= 1'b0;
      DRQ_OE_O <= 1'b0;
      FIFO_ROUTE_O <= 1'b0;
    end else begin
      DRQ_O <= dma_en & DMA_REQ_I;
      DRQ_OE_O <= dma_en;
      FIFO_ROUTE_O <= dma_en;
    end
  end

  // ---------------------------------------------------------------
  // trigger selection
  // ---------------------------------------------------------------
  logic dig_in_edge;
  logic pacer_rise;

  aidt_edge_det #(.RISE(1'b1), .FALL(1'b1)) u_dig_in (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .sig_i(DIGITAL_INPUT_ZERO_I),
    .edge_o(dig_in_edge)
  );

  aidt_edge_det #(.RISE(1'b1), .FALL(1'b0)) u_pacer (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .sig_i(PACER_COUNTER_OUTPUT_I),
    .edge_o(pacer_rise)
  );

  aidt_pkg::aidt_trig_e trig_sel;
  assign trig_sel = aidt_pkg::aidt_trig_e'(ctrl.sample_trigger_source);
  logic trig_raw;

  always_comb begin
    case (trig_sel)
      aidt_pkg::AIDT_TRIG_DIGIN: trig_raw = dig_in_edge;
      aidt_pkg::AIDT_TRIG_PACER: trig_raw = pacer_rise;
      default: trig_raw = SOFT_STROBE_I;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ADC_TRIGGER_O <= 1'b0;
    end else begin
      ADC_TRIGGER_O <= trig_raw & ~conv_dis;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_tc_in_dma;
    TC_I && dma_en;
  endsequence

  sequence s_stopped;
    CONV_DISABLE_O && !ADC_TRIGGER_O;
  endsequence

  chk_reg_write_store: assert property (
    wr_hit |=> (ctrl == $past(IO_DATA_I)))
    else $error("control byte not stored on write");

  chk_irq_invalid_quiet: assert property (
    (!sel.valid) |=> (IRQ_OE_O == 16'h0000) && (IRQ_O == 16'h0000))
    else $error("interrupt line driven for invalid code");

  chk_irq_one_line: assert property (
    $onehot0(IRQ_OE_O) && ((IRQ_O & ~IRQ_OE_O) == 16'h0000))
    else $error("more than one interrupt line driven");

  chk_legacy_irq_map: assert property (
    (!enh && legacy_irq_line_code == 3'h5) |=> IRQ_OE_O == 16'h0020)
    else $error("legacy code 101 does not select line 5");

  chk_adc_gate_off: assert property (
    (!enh && !adc_irq_enable && ADC_DONE_I && !pending && !fifo_set
     && !tc_set) |=> !pending)
    else $error("ADC interrupt passed while disabled");

  chk_fifo_jumper_gate: assert property (
    (!FIFO_SUPERSET_JUMPER_I && FIFO_IRQ_EVENT_I && !adc_set && !tc_set
     && !pending) |=> !pending)
    else $error("FIFO interrupt passed without jumper");

  chk_dma_tristate: assert property (
    !dma_en |=> !DRQ_OE_O && !DRQ_O)
    else $error("DMA request driven while disabled");

  chk_fifo_route: assert property (
    dma_en |=> FIFO_ROUTE_O)
    else $error("FIFO not used in DMA mode");

  chk_tc_irq: assert property (
    (s_tc_in_dma and sel.valid) |=> pending ##1 IRQ_O[$past(sel.line)])
    else $error("terminal count raised no interrupt");

  chk_tc_stop: assert property (
    (s_tc_in_dma and COMPAT_MODE_JUMPER_I) |=> CONV_DISABLE_O ##1 s_stopped)
    else $error("terminal count did not stop conversions");

  chk_resume: assert property (
    (CONV_DISABLE_CLR_I && !tc_stop) |=> !CONV_DISABLE_O)
    else $error("conversions not resumed after clear");

  chk_soft_trigger: assert property (
    (SOFT_STROBE_I && !ctrl.sample_trigger_source[1] && !conv_dis)
    |=> ADC_TRIGGER_O)
    else $error("software strobe did not trigger");

endmodule

// [src/aidt_defines.svh]
/*
  Offsets, field positions and reset values of the acquisition control
  register. Assumes it is included by its bare name wherever it is needed.
*/
`ifndef AIDT_DEFINES_SVH
`define AIDT_DEFINES_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define AIDT_CTRL_OFS 4'h9
`define AIDT_CTRL_RST 8'h00

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define AIDT_LINE_HI 7
`define AIDT_LINE_LO 4
`define AIDT_ADC_IRQ_EN_BIT 7
`define AIDT_FIFO_IRQ_EN_BIT 3
`define AIDT_DMA_EN_BIT 2
`define AIDT_TRIG_HI 1
`define AIDT_TRIG_LO 0

// ---------------------------------------------------------------
// line codes that select the shared low/high interrupt line
// ---------------------------------------------------------------
`define AIDT_CODE_IRQ92_A 4'h2
`define AIDT_CODE_IRQ92_B 4'h9
`define AIDT_LINE_AT 4'h9
`define AIDT_LINE_XT 4'h2

`endif

// [src/aidt_edge_det.sv]
/*
  Single-bit edge detector with selectable polarity.
  Assumes the input is synchronous to CLK_I.
*/
module aidt_edge_det #(
  parameter bit RISE = 1'b1,
  parameter bit FALL = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sig_i,
  output logic edge_o
);

  logic prev;

  if (!RISE && !FALL) begin : g_bad_cfg
    $error("aidt_edge_det: at least one edge must be selected");
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev <= 1'b0;
    end else begin
      prev <= sig_i;
    end
  end

  assign edge_o = (RISE & sig_i & ~prev) | (FALL & ~sig_i & prev);

endmodule

// [src/aidt_pkg.sv]
/*
  Types shared by the acquisition control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package aidt_pkg;

  // stored image of the control byte; bits 7:4 hold either the
  // enhanced line code or the legacy enable plus 3-bit line code
  typedef struct packed {
    logic [3:0] line_nib;
    logic fifo_irq_enable;
    logic dma_request_enable;
    logic [1:0] sample_trigger_source;
  } aidt_ctrl_s;

  typedef enum logic [1:0] {
    AIDT_TRIG_SOFT0 = 2'b00,
    AIDT_TRIG_SOFT1 = 2'b01,
    AIDT_TRIG_DIGIN = 2'b10,
    AIDT_TRIG_PACER = 2'b11
  } aidt_trig_e;

  // decoded interrupt line choice
  typedef struct packed {
    logic valid;
    logic [3:0] line;
  } aidt_line_s;

endpackage
